// ===== src/e1_signaling_ds0_monitor.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sig_mon_defs.svh"
module e1_signaling_ds0_monitor
  import sig_mon_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire line_in_s tx_line,
  input wire line_in_s rx_line,
  output logic tx_data_out,
  output logic tx_data_valid
);

  // ****************************************
  // registers and bus decode
  // ****************************************
  logic [7:0] tx_sel_r;
  logic [7:0] rx_sel_r;
  logic [7:0] sig_ctrl_r;
  logic st_txmf_r;
  logic st_rxmf_r;
  byte_t tx_sig_r [16];
  byte_t rx_sig_r [16];
  logic [127:0] tx_flat;
  logic [127:0] tx_shift_r;
  logic [127:0] rx_acc_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic tx_out_r;
  logic tx_valid_r;
  logic [31:0] rd_data;
  logic mapped;
  logic [5:0] idx;
  logic wr_fire;
  logic ins_en;
  logic rdbk_en;
  logic tx_ins;
  logic tx_bit;

  assign idx = paddr[7:2];
  assign wr_fire = psel & penable & pready_r & pwrite;
  assign ins_en = sig_ctrl_r[`SM_CTRL_INS_BIT];
  assign rdbk_en = sig_ctrl_r[`SM_CTRL_RDBK_BIT];

  // ****************************************
  // per-direction framing and channel monitor
  // ****************************************
  line_in_s line [2];
  logic [7:0] bit_cnt_r [2];
  logic [7:0] pos [2];
  logic line_bit [2];
  logic [6:0] mon_sh_r [2];
  byte_t mon_r [2];
  logic [4:0] chan_sel [2];
  logic in_sel [2];

  assign line[0] = tx_line;
  assign line[1] = rx_line;
  assign line_bit[0] = tx_bit;
  assign line_bit[1] = rx_line.data;
  // (RULE11) transmit channel select
  assign chan_sel[0] = tx_sel_r[`SM_SEL_MSB:0];
  // (RULE12) receive channel select
  assign chan_sel[1] = rx_sel_r[`SM_SEL_MSB:0];

  for (genvar d = 0; d < 2; d++) begin : g_dir
    assign pos[d] = line[d].frame_sync ? 8'h00 : bit_cnt_r[d];
    assign in_sel[d] = line[d].bit_en && (pos[d][7:3] == chan_sel[d]);

    // bit position within the 256-bit frame
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bit_cnt_r[d] <= 8'h00;
      end else if (line[d].bit_en) begin
        bit_cnt_r[d] <= pos[d] + 8'h01;
      end
    end

    // (RULE10) collect selected slot bits
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mon_sh_r[d] <= 7'h00;
      end else if (in_sel[d]) begin
        mon_sh_r[d] <= {mon_sh_r[d][5:0], line_bit[d]};
      end
    end

    // (RULE18) whole byte once per frame, first bit in bit 7
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mon_r[d] <= `SM_RST_BYTE;
      end else if (in_sel[d] && (pos[d][2:0] == 3'h7)) begin
        mon_r[d] <= {mon_sh_r[d], line_bit[d]};
      end
    end
  end

  // ****************************************
  // signaling buffers
  // ****************************************
  for (genvar i = 0; i < 16; i++) begin : g_sig
    // (RULE8) (RULE9) first byte on top of image, alarm nibble in its low half
    assign tx_flat[127-8*i -: 8] = tx_sig_r[i];

    // (RULE2) (RULE6) write loads entry, otherwise it holds
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_sig_r[i] <= `SM_RST_BYTE;
      end else if (wr_fire && (idx == `SM_IDX_SIG_FIRST + 6'(i))) begin
        tx_sig_r[i] <= pwdata[7:0];
      end
    end

    // (RULE17) refresh receive buffer at multiframe boundary
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_sig_r[i] <= `SM_RST_BYTE;
      end else if (rx_line.bit_en && rx_line.mf_sync) begin
        rx_sig_r[i] <= rx_acc_r[127-8*i -: 8];
      end
    end
  end

  // ****************************************
  // transmit insertion
  // ****************************************
  // (RULE1) insert only while enabled and in slot 16
  assign tx_ins = ins_en && (pos[0][7:3] == `SM_TS_SIG);
  assign tx_bit = tx_ins ? tx_shift_r[127] : tx_line.data;

  // (RULE3) load at boundary, shift one bit per slot-16 bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_r <= 128'h0;
    end else if (tx_line.bit_en && tx_line.mf_sync) begin
      tx_shift_r <= tx_flat;
    end else if (tx_line.bit_en && (pos[0][7:3] == `SM_TS_SIG)) begin
      tx_shift_r <= {tx_shift_r[126:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_r <= 1'b0;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= tx_line.bit_en;
      if (tx_line.bit_en) begin
        tx_out_r <= tx_bit;
      end
    end
  end

  // receive slot-16 bits gathered over one multiframe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_acc_r <= 128'h0;
    end else if (rx_line.bit_en && (pos[1][7:3] == `SM_TS_SIG)) begin
      rx_acc_r <= {rx_acc_r[126:0], rx_line.data};
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // (RULE4) set on each transmit multiframe, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_txmf_r <= 1'b0;
    end else if (tx_line.bit_en && tx_line.mf_sync) begin
      st_txmf_r <= 1'b1;
    end else if (wr_fire && idx == `SM_IDX_STATUS &&
                 pwdata[`SM_ST_TXMF_BIT]) begin
      st_txmf_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_rxmf_r <= 1'b0;
    end else if (rx_line.bit_en && rx_line.mf_sync) begin
      st_rxmf_r <= 1'b1;
    end else if (wr_fire && idx == `SM_IDX_STATUS &&
                 pwdata[`SM_ST_RXMF_BIT]) begin
      st_rxmf_r <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sel_r <= `SM_RST_BYTE;
      rx_sel_r <= `SM_RST_BYTE;
      sig_ctrl_r <= `SM_RST_BYTE;
    end else if (wr_fire) begin
      if (idx == `SM_IDX_TX_SEL) begin
        tx_sel_r <= pwdata[7:0];
      end
      if (idx == `SM_IDX_RX_SEL) begin
        rx_sel_r <= pwdata[7:0];
      end
      if (idx == `SM_IDX_SIG_CTRL) begin
        sig_ctrl_r <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // read mux and bus answer
  // ****************************************
  always_comb begin
    rd_data = 32'h0;
    mapped = 1'b1;
    if (idx >= `SM_IDX_SIG_FIRST && idx <= `SM_IDX_SIG_LAST) begin
      // (RULE16) transmit buffer only when readback set
      rd_data[7:0] = rdbk_en ? tx_sig_r[idx[3:0]] : rx_sig_r[idx[3:0]];
    end else begin
      unique case (idx)
        `SM_IDX_TX_SEL: rd_data[7:0] = tx_sel_r;
        `SM_IDX_RX_SEL: rd_data[7:0] = rx_sel_r;
        `SM_IDX_SIG_CTRL: rd_data[7:0] = sig_ctrl_r;
        `SM_IDX_STATUS: begin
          rd_data[`SM_ST_TXMF_BIT] = st_txmf_r;
          rd_data[`SM_ST_RXMF_BIT] = st_rxmf_r;
        end
        // (RULE14) transmit monitor byte
        `SM_IDX_TX_MON: rd_data[7:0] = mon_r[0];
        // (RULE15) receive monitor byte
        `SM_IDX_RX_MON: rd_data[7:0] = mon_r[1];
        default: mapped = 1'b0;
      endcase
    end
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel & penable & ~pready_r & ~pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_data_out = tx_out_r;
  assign tx_data_valid = tx_valid_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_tx_mf;
    tx_line.bit_en && tx_line.mf_sync;
  endsequence

  sequence s_rd_sig1;
    psel && penable && !pwrite && idx == 6'h31 && !pready_r ##1 pready_r;
  endsequence

  sequence s_tx_byte_end;
    in_sel[0] && pos[0][2:0] == 3'h7;
  endsequence

  sequence s_rx_byte_end;
    in_sel[1] && pos[1][2:0] == 3'h7;
  endsequence

  property p_ins_gated;
    @(posedge pclk) disable iff (!presetn)
    (tx_line.bit_en && !ins_en) |=> tx_data_out == $past(tx_line.data);
  endproperty
  a_ins_gated: assert property (p_ins_gated) // (RULE1)
    else $error("bit altered while insertion disabled");

  property p_sig_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && idx == `SM_IDX_SIG_FIRST) |=>
      tx_sig_r[0] == $past(pwdata[7:0]);
  endproperty
  a_sig_write: assert property (p_sig_write) // (RULE2)
    else $error("signaling write not stored");

  property p_shift_load;
    @(posedge pclk) disable iff (!presetn)
    s_tx_mf |=> tx_shift_r == $past(tx_flat);
  endproperty
  a_shift_load: assert property (p_shift_load) // (RULE3)
    else $error("shift register not loaded at boundary");

  property p_txmf_flag;
    @(posedge pclk) disable iff (!presetn)
    s_tx_mf |=> st_txmf_r;
  endproperty
  a_txmf_flag: assert property (p_txmf_flag) // (RULE4)
    else $error("multiframe flag not set");

  property p_sig_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_fire && idx == 6'h31) |=> $stable(tx_sig_r[1]);
  endproperty
  a_sig_hold: assert property (p_sig_hold) // (RULE6)
    else $error("signaling entry changed without write");

  property p_alarm_bits;
    @(posedge pclk) disable iff (!presetn)
    s_tx_mf |=> tx_shift_r[123:120] == $past(tx_sig_r[0][3:0]);
  endproperty
  a_alarm_bits: assert property (p_alarm_bits) // (RULE8)
    else $error("alarm nibble misplaced");

  // the captured byte ends with the last two bits put on the line
  property p_tx_mon;
    @(posedge pclk) disable iff (!presetn)
    s_tx_byte_end |=>
      mon_r[0][1:0] == {$past(tx_data_out), tx_data_out};
  endproperty
  a_tx_mon: assert property (p_tx_mon) // (RULE14)
    else $error("transmit monitor byte wrong");

  property p_rx_mon_hold;
    @(posedge pclk) disable iff (!presetn)
    !(in_sel[1] && pos[1][2:0] == 3'h7) |=> $stable(mon_r[1]);
  endproperty
  a_rx_mon_hold: assert property (p_rx_mon_hold) // (RULE18)
    else $error("receive monitor changed mid-frame");

  property p_rd_back;
    @(posedge pclk) disable iff (!presetn)
    s_rd_sig1 |-> prdata[7:0] ==
      (rdbk_en ? tx_sig_r[1] : rx_sig_r[1]);
  endproperty
  a_rd_back: assert property (p_rd_back) // (RULE16)
    else $error("signaling read source wrong");

  property p_rx_refresh;
    @(posedge pclk) disable iff (!presetn)
    !(rx_line.bit_en && rx_line.mf_sync) |=> $stable(rx_sig_r[2]);
  endproperty
  a_rx_refresh: assert property (p_rx_refresh) // (RULE17)
    else $error("receive buffer changed off boundary");

  property p_rx_mon;
    @(posedge pclk) disable iff (!presetn)
    s_rx_byte_end |=> mon_r[1][0] == $past(rx_line.data);
  endproperty
  a_rx_mon: assert property (p_rx_mon) // (RULE15)
    else $error("receive monitor last bit wrong");

  property p_rxmf_flag;
    @(posedge pclk) disable iff (!presetn)
    (rx_line.bit_en && rx_line.mf_sync) |=> st_rxmf_r;
  endproperty
  a_rxmf_flag: assert property (p_rxmf_flag) // (RULE17)
    else $error("receive multiframe flag not set");

endmodule // e1_signaling_ds0_monitor
`default_nettype wire

// ===== src/sig_mon_defs.svh
//Contract
//(RULE1) insert signaling only when insertion bit set
//(RULE2) host write loads transmit signaling buffer byte
//(RULE3) multiframe boundary copies buffer into shift register
//(RULE4) set transmit multiframe flag each multiframe
//(RULE5) host refreshes signaling within one multiframe
//(RULE6) buffer entries hold value across multiframes
//(RULE7) host writes zero alignment nibble in CAS
//(RULE8) first byte low nibble carries alarm bits
//(RULE9) sixteen consecutive signaling registers, channel nibbles
//(RULE10) one transmit and one receive channel monitored
//(RULE11) transmit select field picks transmit monitor byte
//(RULE12) receive select field picks receive monitor byte
//(RULE13) host programs binary channel number
//(RULE14) transmit monitor bit 7 sent first
//(RULE15) receive monitor bit 7 received first
//(RULE16) signaling reads return receive unless readback set
//(RULE17) receive buffers refresh only at multiframe boundary
//(RULE18) monitors update once per frame, whole byte
`ifndef SIG_MON_DEFS_SVH
`define SIG_MON_DEFS_SVH
// register indexes, byte address is four times the index
`define SM_IDX_TX_SEL 6'h14
`define SM_IDX_RX_SEL 6'h15
`define SM_IDX_SIG_CTRL 6'h1a
`define SM_IDX_STATUS 6'h1b
`define SM_IDX_TX_MON 6'h22
`define SM_IDX_RX_MON 6'h2a
`define SM_IDX_SIG_FIRST 6'h30
`define SM_IDX_SIG_LAST 6'h3f
// field positions
`define SM_SEL_MSB 4
`define SM_CTRL_INS_BIT 3
`define SM_CTRL_RDBK_BIT 5
`define SM_ST_TXMF_BIT 5
`define SM_ST_RXMF_BIT 7
// reset values
`define SM_RST_BYTE 8'h00
// time slot 16 in the 5-bit slot number
`define SM_TS_SIG 5'h10
`endif

// ===== src/sig_mon_pkg.sv
package sig_mon_pkg;
  // one line direction, sampled on pclk
  typedef struct packed {
    logic bit_en;
    logic frame_sync;
    logic mf_sync;
    logic data;
  } line_in_s;
  typedef logic [7:0] byte_t;
endpackage

// ===== verif/host_apb_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_apb_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****
  // host side of the register bus
  // ****
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale values
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // host_apb_model
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sig_mon_defs.svh"
module tb_top
  import sig_mon_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic tx_data_out, tx_data_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  line_in_s tx_line, rx_line;
  byte_t sig [16];
  byte_t rd;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  e1_signaling_ds0_monitor i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_line(tx_line), .rx_line(rx_line), .tx_data_out(tx_data_out),
    .tx_data_valid(tx_data_valid));
  host_apb_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // ****
  // helpers
  // ****
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test;
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    i_host.xfer(1'b1, idx, d, rd, err);
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp,
                        input string msg);
    i_host.xfer(1'b0, idx, 8'h00, rd, err);
    check(rd, exp, msg);
  endtask
  function automatic logic tx_bit(int f, int p);
    byte_t b;
    b = {p[6:3], f[3:0]};
    return b[3'd7 - p[2:0]];
  endfunction
  function automatic logic rx_bit(int f, int p);
    byte_t b;
    b = {f[3:0], p[6:3]} ^ 8'h5a;
    return b[3'd7 - p[2:0]];
  endfunction
  // frames from a multiframe start; outgoing bits checked one cycle late
  task automatic send(input int nf, input logic ins);
    logic exp_r;
    logic exp_nx;
    exp_r = 1'b0;
    for (int f = 0; f < nf; f++) begin
      for (int p = 0; p < 256; p++) begin
        @(posedge pclk);
        tx_line <= '{1'b1, p == 0, p == 0 && f == 0, tx_bit(f, p)};
        rx_line <= '{1'b1, p == 0, p == 0 && f == 0, rx_bit(f, p)};
        exp_nx = (ins && p[7:3] == `SM_TS_SIG) ? sig[f][3'd7 - p[2:0]]
                                               : tx_bit(f, p);
        @(negedge pclk);
        if (f + p > 0)
          check({tx_data_valid, tx_data_out}, {1'b1, exp_r}, "tx bit");
        exp_r = exp_nx;
      end
    end
    @(posedge pclk);
    tx_line <= '0;
    rx_line <= '0;
    @(negedge pclk);
    check({tx_data_valid, tx_data_out}, {1'b1, exp_r}, "tx last bit");
  endtask
  // ****
  // main sequence
  // ****
  task automatic t_reset_values;
    rd_chk(`SM_IDX_TX_SEL, 8'h00, "tx select reset");
    rd_chk(`SM_IDX_RX_SEL, 8'h00, "rx select reset");
    rd_chk(`SM_IDX_STATUS, 8'h00, "status reset");
  endtask
  task automatic t_sig_buffers;
    for (int i = 0; i < 16; i++)
      sig[i] = (i == 0) ? 8'h0a : 8'(i * 37 + 1);
    wr(`SM_IDX_SIG_CTRL, 8'h28);
    for (int i = 0; i < 16; i++)
      wr(`SM_IDX_SIG_FIRST + 6'(i), sig[i]);
    for (int i = 0; i < 16; i++)
      rd_chk(`SM_IDX_SIG_FIRST + 6'(i), sig[i], "readback");
  endtask
  task automatic t_selects;
    wr(`SM_IDX_TX_SEL, 8'h05);
    wr(`SM_IDX_RX_SEL, 8'h15);
    rd_chk(`SM_IDX_TX_SEL, 8'h05, "tx select");
    rd_chk(`SM_IDX_RX_SEL, 8'h15, "rx select");
  endtask
  // both multiframe flags rise; clearing one leaves the other
  task automatic t_insert_flags;
    send(16, 1'b1);
    rd_chk(`SM_IDX_STATUS, 8'ha0, "mf flags set");
    wr(`SM_IDX_STATUS, 8'h20);
    rd_chk(`SM_IDX_STATUS, 8'h80, "tx mf flag clear");
  endtask
  task automatic t_monitors;
    send(16, 1'b1);
    rd_chk(`SM_IDX_TX_MON, 8'h5f, "tx monitor");
    wr(`SM_IDX_TX_MON, 8'h00);
    rd_chk(`SM_IDX_TX_MON, 8'h5f, "tx monitor read only");
    rd_chk(`SM_IDX_RX_MON, 8'hf5 ^ 8'h5a, "rx monitor");
  endtask
  task automatic t_rx_signaling;
    wr(`SM_IDX_SIG_CTRL, 8'h08);
    for (int i = 0; i < 16; i++)
      rd_chk(`SM_IDX_SIG_FIRST + 6'(i), {4'(i), 4'h0} ^ 8'h5a,
             "rx signaling");
  endtask
  task automatic t_ins_off;
    wr(`SM_IDX_SIG_CTRL, 8'h00);
    send(1, 1'b0);
  endtask
  task automatic t_unmapped;
    i_host.xfer(1'b0, 6'h00, 8'h00, rd, err);
    check({7'h0, err}, 8'h01, "unmapped error");
    check(rd, 8'h00, "unmapped read");
  endtask
  initial begin
    presetn = 1'b0;
    tx_line = '0;
    rx_line = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_sig_buffers();
    t_selects();
    t_insert_flags();
    t_monitors();
    t_rx_signaling();
    t_ins_off();
    t_unmapped();
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
